// file: verilog/ptim_pkg.sv
// Purpose: Shared constants and types for the 8-bit period timer.
// Assumes: One clock domain, plain register port with 8-bit data.
// Notes: Register offsets are word indices on the register port.
package ptim_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_COUNT = 4'h1;
	localparam logic [3:0] ADDR_PERIOD = 4'h2;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int PRESCALE_LSB = 0;
	localparam int RUN_BIT_POS = 2;
	localparam int POSTSCALE_LSB = 3;
	localparam int MATCH_FLAG_POS = 0;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] PERIOD_RESET = 8'hFF;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// ----------------------------------------
	// Prescale ratios (input clocks per pulse, minus one)
	// ----------------------------------------
	localparam logic [3:0] PRESCALE_DIV1_LAST = 4'h0;
	localparam logic [3:0] PRESCALE_DIV4_LAST = 4'h3;
	localparam logic [3:0] PRESCALE_DIV16_LAST = 4'hF;
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic unused;
		logic [3:0] postscale_select;
		logic run_bit;
		logic [1:0] prescale_select;
	} ptim_control_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ptim_req_t;
endpackage

// file: verilog/ptim_timer.sv
// Purpose: 8-bit period timer with prescaler, postscaler and match interrupt.
// Assumes: mclk is the oscillator; the instruction clock is mclk divided by four.
// Notes: Register reads return data in the cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none
module ptim_timer (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Interrupt
	output logic irq
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	ptim_pkg::ptim_control_t ctrl_q;
	logic [7:0] count_q, count_d;
	logic [7:0] period_q;
	logic [1:0] instr_div_q;
	logic [3:0] pre_cnt_q, pre_cnt_d;
	logic [3:0] post_cnt_q, post_cnt_d;
	logic flag_q, mask_q;
	logic [7:0] rdata_q;
	ptim_pkg::ptim_req_t req;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire wr_ctrl = req.wr && (req.addr == ptim_pkg::ADDR_CONTROL);
	wire wr_count = req.wr && (req.addr == ptim_pkg::ADDR_COUNT);
	wire wr_period = req.wr && (req.addr == ptim_pkg::ADDR_PERIOD);
	wire wr_status = req.wr && (req.addr == ptim_pkg::ADDR_IRQ_STATUS);
	wire wr_mask = req.wr && (req.addr == ptim_pkg::ADDR_IRQ_MASK);

	// ----------------------------------------
	// Timing chain
	// ----------------------------------------
	// run gate
	wire running = ctrl_q.run_bit;
	// instruction clock tick, one mclk in four
	wire instr_tick = running && (instr_div_q == ptim_pkg::INSTR_DIV_LAST);
	wire [3:0] pre_last = ctrl_q.prescale_select[1] ? ptim_pkg::PRESCALE_DIV16_LAST :
		ctrl_q.prescale_select[0] ? ptim_pkg::PRESCALE_DIV4_LAST :
		ptim_pkg::PRESCALE_DIV1_LAST;
	wire pre_pulse = instr_tick && (pre_cnt_q >= pre_last);
	wire match = (count_q == period_q);
	wire match_step = pre_pulse && match;
	wire post_pulse = match_step && (post_cnt_q >= ctrl_q.postscale_select);
	// Any write to count or control restarts both scalers
	wire scaler_clr = wr_ctrl || wr_count;

	always_comb begin
		pre_cnt_d = pre_cnt_q;
		post_cnt_d = post_cnt_q;
		count_d = count_q;
		if (scaler_clr) begin
			pre_cnt_d = 4'h0;
			post_cnt_d = 4'h0;
		end else if (instr_tick) begin
			pre_cnt_d = pre_pulse ? 4'h0 : pre_cnt_q + 4'h1;
			if (match_step) begin
				post_cnt_d = post_pulse ? 4'h0 : post_cnt_q + 4'h1;
			end
		end
		if (wr_count) begin
			count_d = req.wdata;
		end else if (pre_pulse) begin
			// wrap to zero after match; else increment
			count_d = match ? 8'h00 : count_q + 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= ptim_pkg::COUNT_RESET;
			period_q <= ptim_pkg::PERIOD_RESET;
			ctrl_q <= ptim_pkg::CONTROL_RESET;
			pre_cnt_q <= 4'h0;
			post_cnt_q <= 4'h0;
			instr_div_q <= 2'h0;
		end else begin
			count_q <= count_d;
			pre_cnt_q <= pre_cnt_d;
			post_cnt_q <= post_cnt_d;
			instr_div_q <= scaler_clr ? 2'h0 : (running ? instr_div_q + 2'h1 : instr_div_q);
			if (wr_period) begin
				period_q <= req.wdata;
			end
			if (wr_ctrl) begin
				ctrl_q <= {1'b0, req.wdata[6:0]};
			end
		end
	end

	// ----------------------------------------
	// Interrupt
	// ----------------------------------------
	// flag set wins over clear; sticky until cleared
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			flag_q <= 1'b0;
			mask_q <= 1'b0;
		end else begin
			flag_q <= post_pulse || (flag_q && !(wr_status && req.wdata[ptim_pkg::MATCH_FLAG_POS]));
			if (wr_mask) begin
				mask_q <= req.wdata[ptim_pkg::MATCH_FLAG_POS];
			end
		end
	end

	assign irq = flag_q && mask_q;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire [7:0] rd_mux = (req.addr == ptim_pkg::ADDR_CONTROL) ? ctrl_q :
		(req.addr == ptim_pkg::ADDR_COUNT) ? count_q :
		(req.addr == ptim_pkg::ADDR_PERIOD) ? period_q :
		(req.addr == ptim_pkg::ADDR_IRQ_STATUS) ? {7'h00, flag_q} :
		(req.addr == ptim_pkg::ADDR_IRQ_MASK) ? {7'h00, mask_q} : 8'h00;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= req.rd ? rd_mux : 8'h00;
		end
	end
	assign reg_rdata = rdata_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence match_inc_s;
		pre_pulse && match && !wr_count;
	endsequence

	wrap_zero_a: assert property (match_inc_s |=> count_q == 8'h00)
		else $error("count did not wrap after match");
	count_inc_a: assert property (pre_pulse && !match && !wr_count |=> count_q == $past(count_q) + 8'h01)
		else $error("count did not increment");
	stop_hold_a: assert property (!running && !req.wr |=> $stable(count_q) && $stable(pre_cnt_q) && $stable(post_cnt_q))
		else $error("timer moved while stopped");
	scaler_clear_a: assert property (scaler_clr |=> pre_cnt_q == 4'h0 && post_cnt_q == 4'h0)
		else $error("scalers not cleared by write");
	ctrl_keep_a: assert property (wr_ctrl && !pre_pulse |=> count_q == $past(count_q))
		else $error("control write changed count");
	flag_set_a: assert property (post_pulse |=> flag_q)
		else $error("flag not set by postscaler");
	irq_level_a: assert property (irq == (flag_q && mask_q))
		else $error("interrupt does not follow flag and enable");
	div4_tick_a: assert property (instr_tick |=> !instr_tick [*3])
		else $error("instruction tick faster than one in four");
	pre16_a: assert property (pre_pulse && ctrl_q.prescale_select[1] && !scaler_clr |=> !pre_pulse [*8])
		else $error("divide-by-sixteen pulse too early");
	post_ratio_a: assert property (post_pulse |-> post_cnt_q == ctrl_q.postscale_select)
		else $error("postscale ratio wrong");
	run_gate_a: assert property (pre_pulse |-> running)
		else $error("prescaler pulse while stopped");

	// ----------------------------------------
	// Register and scaler checks
	// ----------------------------------------
	sequence run_write_s;
		wr_ctrl && req.wdata[ptim_pkg::RUN_BIT_POS];
	endsequence

	sequence stop_write_s;
		wr_ctrl && !req.wdata[ptim_pkg::RUN_BIT_POS];
	endsequence

	sequence quiet_run_s;
		(running && !scaler_clr) [*3];
	endsequence

	period_write_a: assert property (wr_period |=> period_q == $past(req.wdata))
		else $error("period write lost");

	count_write_a: assert property (wr_count |=> count_q == $past(req.wdata))
		else $error("count write lost");

	read_data_a: assert property (req.rd |=> reg_rdata == $past(rd_mux))
		else $error("read data wrong");

	read_idle_a: assert property (!req.rd |=> reg_rdata == 8'h00)
		else $error("read data not zero when idle");

	first_tick_a: assert property (run_write_s ##1 quiet_run_s |=> instr_tick)
		else $error("first instruction tick late");

	tick_run_a: assert property (instr_tick |-> running)
		else $error("instruction tick while stopped");

	pre_adv_a: assert property (instr_tick && !pre_pulse && !scaler_clr |=> pre_cnt_q == $past(pre_cnt_q) + 4'h1)
		else $error("prescaler did not advance");

	pre_wrap_a: assert property (pre_pulse && !scaler_clr |=> pre_cnt_q == 4'h0)
		else $error("prescaler did not wrap");

	pre_bound_a: assert property (pre_cnt_q <= pre_last)
		else $error("prescaler beyond its ratio");

	pulse_tick_a: assert property (pre_pulse |-> instr_tick)
		else $error("prescaler pulse without tick");

	count_hold_a: assert property (!pre_pulse && !wr_count |=> $stable(count_q))
		else $error("count moved without pulse");

	div1_a: assert property (instr_tick && ctrl_q.prescale_select == 2'b00 |-> pre_pulse)
		else $error("divide-by-one missed a tick");

	div4_a: assert property (pre_pulse && ctrl_q.prescale_select == 2'b01 && !scaler_clr |=> !pre_pulse [*8])
		else $error("divide-by-four pulse too early");

	post_adv_a: assert property (match_step && !post_pulse && !scaler_clr |=> post_cnt_q == $past(post_cnt_q) + 4'h1)
		else $error("postscaler did not advance");

	post_hold_a: assert property (!match_step && !scaler_clr |=> $stable(post_cnt_q))
		else $error("postscaler moved without match");

	post_wrap_a: assert property (post_pulse && !scaler_clr |=> post_cnt_q == 4'h0)
		else $error("postscaler did not wrap");

	post_bound_a: assert property (post_cnt_q <= ctrl_q.postscale_select)
		else $error("postscaler beyond its ratio");

	post_match_a: assert property (post_pulse |-> match_step)
		else $error("postscaler output without match");

	flag_quiet_a: assert property (!flag_q && !post_pulse |=> !flag_q)
		else $error("flag set without postscaler output");

	flag_hold_a: assert property (flag_q && !(wr_status && req.wdata[ptim_pkg::MATCH_FLAG_POS]) |=> flag_q)
		else $error("flag dropped without clear");

	flag_clear_a: assert property (wr_status && req.wdata[ptim_pkg::MATCH_FLAG_POS] && !post_pulse |=> !flag_q)
		else $error("flag not cleared");

	mask_write_a: assert property (wr_mask |=> mask_q == $past(req.wdata[ptim_pkg::MATCH_FLAG_POS]))
		else $error("enable write lost");

	run_on_a: assert property (run_write_s |=> running)
		else $error("timer did not start");

	run_off_a: assert property (stop_write_s |=> !running)
		else $error("timer did not stop");

	ctrl_write_a: assert property (wr_ctrl |=> ctrl_q == {1'b0, $past(req.wdata[6:0])})
		else $error("control write lost");

	bit7_zero_a: assert property (ctrl_q.unused == 1'b0)
		else $error("control bit seven set");
endmodule
`default_nettype wire

// file: verification/test_ptim_timer.sv
// Purpose: Self-checking bench for the 8-bit period timer.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes: Match timing allows a few cycles of slack for the tick phase.
`timescale 1ns/1ns
`default_nettype none
module test_ptim_timer;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic irq;
	logic rd_pend = 1'b0;
	logic [7:0] exp_q[$];
	int num_errors = 0;
	int total_checks = 0;
	int seed = 32'h081d;
	int n;
	logic [7:0] v;
	always #20 mclk = ~mclk;
	ptim_timer i_dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));
	// ----------------------------------------
	// Checking and verdict
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// Register port
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		// One idle edge so a following strobe is not assigned twice in one step
		@(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
	endtask
	// Sampled mid-cycle, where the one-cycle read data has settled
	always @(posedge mclk) rd_pend <= reg_rd;
	always @(negedge mclk) begin
		if (rd_pend)
			chk("read data", reg_rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
	end
	task automatic irq_is(input logic e);
		repeat (2) @(negedge mclk);
		chk("irq", {7'h00, irq}, {7'h00, e});
		@(posedge mclk);
	endtask
	// ----------------------------------------
	// Time from start to flag, per prescale and postscale code
	// ----------------------------------------
	task automatic timed(input logic [1:0] pre, input logic [3:0] post, input logic [7:0] per);
		int lim;
		lim = 4 * ((pre == 2'b00) ? 1 : (pre == 2'b01) ? 4 : 16) * (per + 1) * (post + 1);
		wr(ptim_pkg::ADDR_CONTROL, 8'h00);
		wr(ptim_pkg::ADDR_PERIOD, per);
		wr(ptim_pkg::ADDR_IRQ_STATUS, 8'h01);
		wr(ptim_pkg::ADDR_COUNT, 8'h00);
		wr(ptim_pkg::ADDR_CONTROL, {1'b0, post, 1'b1, pre});
		n = 0;
		while (irq !== 1'b1 && n < lim + 8) begin
			@(posedge mclk);
			n++;
		end
		if (n >= lim + 8) begin
			num_errors++;
			conclude();
		end
		chk("match time", {7'h00, n >= lim - 4 && n <= lim + 4}, 8'h01);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		rd(ptim_pkg::ADDR_COUNT, 8'h00);
		rd(ptim_pkg::ADDR_PERIOD, 8'hFF);
		rd(ptim_pkg::ADDR_CONTROL, 8'h00);
		rd(4'h7, 8'h00);
		v = 8'($random(seed));
		wr(ptim_pkg::ADDR_PERIOD, v);
		rd(ptim_pkg::ADDR_PERIOD, v);
		wr(ptim_pkg::ADDR_COUNT, ~v);
		rd(ptim_pkg::ADDR_COUNT, ~v);
		wr(ptim_pkg::ADDR_CONTROL, 8'hFB);
		rd(ptim_pkg::ADDR_CONTROL, 8'h7B);
		rd(ptim_pkg::ADDR_COUNT, ~v);
		wr(ptim_pkg::ADDR_IRQ_MASK, 8'h01);
		rd(ptim_pkg::ADDR_IRQ_MASK, 8'h01);
		for (int p = 0; p < 4; p++) begin
			timed(2'(p), 4'h0, 8'h02 + 8'(p));
			timed(2'(p), 4'h5, 8'h03);
			timed(2'(p), 4'hF, 8'($random(seed)) & 8'h03);
		end
		wr(ptim_pkg::ADDR_CONTROL, 8'h00);
		repeat (20) @(posedge mclk);
		irq_is(1'b1);
		rd(ptim_pkg::ADDR_IRQ_STATUS, 8'h01);
		wr(ptim_pkg::ADDR_IRQ_MASK, 8'h00);
		irq_is(1'b0);
		wr(ptim_pkg::ADDR_IRQ_STATUS, 8'h01);
		rd(ptim_pkg::ADDR_IRQ_STATUS, 8'h00);
		wr(ptim_pkg::ADDR_IRQ_MASK, 8'h01);
		irq_is(1'b0);
		repeat (4) @(posedge mclk);
		conclude();
	end
endmodule
`default_nettype wire
